// ### aoa_pkg.sv
// constants, register map and types for the angle-of-arrival state sequencer
// assumes a 100 MHz system clock; times are in microseconds
package aoa_pkg;
  localparam int CLK_MHZ = 100;
  localparam int TRIG_START_MIN_US = 2900;
  localparam int TRIG_START_MAX_US = 4300;
  localparam int TRANS_MAX_US = 800;
  localparam int TRIG_HIGH_MIN_US = 1;
  localparam int MS_US = 1000;
  // trig_to_transition_start: chosen mid-window, rounded down to whole cycles
  localparam int TRIG_START_MIN_CYC = TRIG_START_MIN_US * CLK_MHZ;
  localparam int TRIG_START_MAX_CYC = TRIG_START_MAX_US * CLK_MHZ;
  localparam int TRIG_DELAY_CYC = (TRIG_START_MIN_CYC + TRIG_START_MAX_CYC) / 2;
  // transition_length, longest time rounds down
  localparam int TRANS_CYC = TRANS_MAX_US * CLK_MHZ;
  localparam int FWD_HIGH_CYC = TRIG_HIGH_MIN_US * CLK_MHZ;
  localparam int CYC_PER_MS = MS_US * CLK_MHZ;

  localparam int NPATH_DEF = 6;
  localparam int ANG_W = 12;
  localparam int DLY_W = 16;
  localparam int DOFS_W = 10;
  localparam int DUR_W = 16;
  localparam logic [ANG_W-1:0] PHASE_MAX = 12'hE10;
  localparam logic [ANG_W-1:0] SPREAD_MAX = 12'h708;
  localparam logic [DOFS_W-1:0] DOFS_MAX = 10'h3E8;
  localparam logic [DLY_W-1:0] DLY_RANGE_MAX = 16'h2710;
  localparam logic [DUR_W-1:0] DUR_MIN = 16'h0004;
  localparam logic [DUR_W-1:0] DUR_MAX = 16'hEA60;
  localparam logic [DUR_W-1:0] DUR_RST = 16'h0004;
  localparam logic [15:0] RANDOM_STATES = 16'h0400;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DUR = 8'h08;
  localparam logic [2:0] GRP_ANGLE = 3'h1;
  localparam logic [2:0] GRP_PHASE = 3'h2;
  localparam logic [2:0] GRP_DOFS = 3'h3;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_LIN = 1;
  localparam int CTRL_EXT = 2;
  localparam int CTRL_PRI = 3;
  localparam int SPREAD_LSB = 16;

  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } seq_state_t;
endpackage : aoa_pkg

// ### aoa_trig_edge.sv
// two-flop synchroniser and rising-edge detector for a trigger line
// assumes the line is held high at least a few clock periods
`timescale 1ns/1ps
`default_nettype none
module aoa_trig_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic evt
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic evt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      evt_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
      evt_r <= sync_r & ~prev_r;
    end
  end
  assign evt = evt_r;

  a_edge_once: assert property (@(posedge clk) disable iff (!rst_n) evt |=> !evt)
    else $error("trigger event longer than one cycle");
  a_edge_cause: assert property (@(posedge clk) disable iff (!rst_n)
    evt |-> $past(sync_r) && !$past(prev_r))
    else $error("trigger event without a rising edge");
endmodule : aoa_trig_edge
`default_nettype wire

// ### aoa_path_angle.sv
// arrival-angle generator for one path: uniform pseudo-random or linear sweep
// assumes mean and spread stay constant while stepping
`timescale 1ns/1ps
`default_nettype none
module aoa_path_angle import aoa_pkg::*; #(
  parameter logic [15:0] SEED = LFSR_SEED
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic step,
  input wire logic linear,
  input wire logic [ANG_W-1:0] mean,
  input wire logic [ANG_W-1:0] spread,
  output logic [ANG_W-1:0] angle
);
  logic [15:0] lfsr_r;
  logic [ANG_W:0] ofs_r;
  logic [ANG_W-1:0] angle_r;
  logic [ANG_W:0] ofs_nxt;
  logic signed [ANG_W+2:0] sum;
  logic [ANG_W-1:0] angle_nxt;

  wire [ANG_W:0] span = {spread, 1'b0};
  wire [ANG_W+16:0] prod = lfsr_r * (span + 13'h0001);
  wire [ANG_W:0] rnd_ofs = prod[ANG_W+16:16];
  wire [ANG_W:0] lin_ofs = (ofs_r >= span) ? 13'h0000 : ofs_r + 13'h0001;
  wire [15:0] lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1);

  // offset runs 0..2*spread, angle = mean - spread + offset, wrapped to a circle
  always_comb begin
    ofs_nxt = ofs_r;
    if (load) begin
      ofs_nxt = {1'b0, spread};
    end else if (step) begin
      ofs_nxt = linear ? lin_ofs : rnd_ofs;
    end
    sum = $signed({3'b000, mean}) + $signed({2'b00, ofs_nxt}) - $signed({3'b000, spread});
    if (sum < 0) begin
      sum = sum + $signed({3'b000, PHASE_MAX});
    end else if (sum >= $signed({3'b000, PHASE_MAX})) begin
      sum = sum - $signed({3'b000, PHASE_MAX});
    end
    angle_nxt = sum[ANG_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_r <= LFSR_SEED;
      ofs_r <= 13'h0000;
      angle_r <= 12'h000;
    end else begin
      if (load) begin
        lfsr_r <= SEED;
      end else if (step) begin
        lfsr_r <= lfsr_nxt;
      end
      ofs_r <= ofs_nxt;
      angle_r <= angle_nxt;
    end
  end
  assign angle = angle_r;

  a_rand_range: assert property (@(posedge clk) disable iff (!rst_n)
    step && !load && !linear |=> ofs_r <= span && angle_r < PHASE_MAX)
    else $error("random angle outside the spread");
endmodule : aoa_path_angle
`default_nettype wire

// ### aoa_state_sequencer.sv
// angle-of-arrival state sequencer: AHB-Lite registers, trigger timing, per-path offsets
// assumes one 100 MHz clock; trigger pins are synchronised here; word accesses only
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module aoa_state_sequencer import aoa_pkg::*; #(
  parameter int NPATH = NPATH_DEF,
  parameter int TRIG_DELAY_CYCLES = TRIG_DELAY_CYC,
  parameter int TRANS_CYCLES = TRANS_CYC,
  parameter int MS_CYCLES = CYC_PER_MS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_trig_in,
  input wire logic sync_trig_in,
  output logic sync_trig_out,
  input wire logic [NPATH*DLY_W-1:0] path_delay_base,
  output logic [NPATH*DLY_W-1:0] path_delay_out,
  output logic [NPATH*ANG_W-1:0] angle_out,
  output logic [NPATH*ANG_W-1:0] phase_ofs_out,
  output logic state_strobe,
  output logic transition_busy,
  output logic params_frozen
);
  localparam int DCW = $clog2(TRIG_DELAY_CYCLES + 1);
  localparam int TCW = $clog2(TRANS_CYCLES + 1);
  localparam int MCW = $clog2(MS_CYCLES + 1);
  localparam int FCW = $clog2(FWD_HIGH_CYC + 1);

  // ---------------- AHB-Lite slave ----------------
  logic [ADDR_W-1:0] addr_r;
  logic wr_ph_r;
  logic rd_ph_r;
  logic rd_dv_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;

  wire ahb_take = hsel && hready && htrans[1];
  wire wr_en = wr_ph_r;
  wire [2:0] a_grp = addr_r[7:5];
  wire [2:0] a_idx = addr_r[4:2];
  wire idx_ok = (32'(a_idx) < NPATH) && (addr_r[1:0] == 2'b00);
  wire hit_ctrl = (addr_r == ADDR_CTRL);
  wire hit_stat = (addr_r == ADDR_STATUS);
  wire hit_dur = (addr_r == ADDR_DUR);
  wire hit_ang = idx_ok && (a_grp == GRP_ANGLE);
  wire hit_phs = idx_ok && (a_grp == GRP_PHASE);
  wire hit_dof = idx_ok && (a_grp == GRP_DOFS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 8'h00;
      wr_ph_r <= 1'b0;
      rd_ph_r <= 1'b0;
    end else if (hready) begin
      wr_ph_r <= ahb_take && hwrite;
      rd_ph_r <= ahb_take && !hwrite;
      if (ahb_take) begin
        addr_r <= haddr[ADDR_W-1:0];
      end
    end
  end

  // reads take one wait state so a write just before is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dv_r <= 1'b0;
      hrdata_r <= 32'h00000000;
    end else begin
      rd_dv_r <= rd_ph_r && !rd_dv_r;
      if (rd_ph_r && !rd_dv_r) begin
        hrdata_r <= rd_mux;
      end
    end
  end
  assign hreadyout = !(rd_ph_r && !rd_dv_r);
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // ---------------- registers ----------------
  logic run_r;
  logic lin_r;
  logic ext_r;
  logic pri_r;
  logic [DUR_W-1:0] dur_r;
  logic [ANG_W-1:0] mean_r [NPATH];
  logic [ANG_W-1:0] spread_r [NPATH];
  logic [ANG_W-1:0] phase_r [NPATH];
  logic [DOFS_W-1:0] dofs_r [NPATH];
  seq_state_t st_r;
  seq_state_t st_nxt;

  wire running = (st_r != ST_STOP);
  wire cfg_open = !running && !run_r;
  wire [DUR_W-1:0] dur_wr = hwdata[DUR_W-1:0];
  wire [DUR_W-1:0] dur_clip = (dur_wr < DUR_MIN) ? DUR_MIN : (dur_wr > DUR_MAX) ? DUR_MAX : dur_wr;
  wire [ANG_W-1:0] wr_mean = hwdata[ANG_W-1:0];
  wire [ANG_W-1:0] wr_spread = hwdata[SPREAD_LSB+ANG_W-1:SPREAD_LSB];
  wire [ANG_W-1:0] wr_phase = hwdata[ANG_W-1:0];
  wire [DOFS_W-1:0] wr_dofs = hwdata[DOFS_W-1:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 1'b0;
      lin_r <= 1'b0;
      ext_r <= 1'b0;
      pri_r <= 1'b1;
      dur_r <= DUR_RST;
    end else begin
      if (wr_en && hit_ctrl) begin
        run_r <= hwdata[CTRL_RUN];
        if (cfg_open) begin
          lin_r <= hwdata[CTRL_LIN];
          ext_r <= hwdata[CTRL_EXT];
          pri_r <= hwdata[CTRL_PRI];
        end
      end
      if (wr_en && hit_dur && cfg_open) begin
        dur_r <= dur_clip;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NPATH; i++) begin
        mean_r[i] <= 12'h000;
        spread_r[i] <= 12'h000;
        phase_r[i] <= 12'h000;
        dofs_r[i] <= 10'h000;
      end
    end else if (wr_en && cfg_open) begin
      for (int i = 0; i < NPATH; i++) begin
        if (32'(a_idx) == i) begin
          if (hit_ang) begin
            mean_r[i] <= (wr_mean >= PHASE_MAX) ? PHASE_MAX - 12'h001 : wr_mean;
            spread_r[i] <= (wr_spread > SPREAD_MAX) ? SPREAD_MAX : wr_spread;
          end
          if (hit_phs) begin
            phase_r[i] <= (wr_phase > PHASE_MAX) ? PHASE_MAX : wr_phase;
          end
          if (hit_dof) begin
            dofs_r[i] <= (wr_dofs > DOFS_MAX) ? DOFS_MAX : wr_dofs;
          end
        end
      end
    end
  end

  // ---------------- trigger path ----------------
  logic ext_evt;
  logic cab_evt;
  logic [FCW-1:0] fwd_cnt_r;

  aoa_trig_edge u_ext_edge (
    .clk(hclk),
    .rst_n(hresetn),
    .din(ext_trig_in),
    .evt(ext_evt)
  );
  aoa_trig_edge u_cab_edge (
    .clk(hclk),
    .rst_n(hresetn),
    .din(sync_trig_in),
    .evt(cab_evt)
  );

  // primary takes the pin and forwards a pulse; secondaries follow the cable
  wire trig_evt = pri_r ? ext_evt : cab_evt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_cnt_r <= '0;
    end else if (pri_r && ext_evt) begin
      fwd_cnt_r <= FCW'(FWD_HIGH_CYC);
    end else if (fwd_cnt_r != '0) begin
      fwd_cnt_r <= fwd_cnt_r - FCW'(1);
    end
  end
  assign sync_trig_out = (fwd_cnt_r != '0);

  // ---------------- state timing ----------------
  logic [DCW-1:0] dly_cnt_r;
  logic [TCW-1:0] tr_cnt_r;
  logic [MCW-1:0] pre_cnt_r;
  logic [DUR_W-1:0] ms_cnt_r;
  logic [15:0] st_idx_r;

  wire run_go = (st_r == ST_STOP) && run_r;
  wire in_run = (st_r == ST_RUN);
  wire trig_ok = in_run && ext_r && trig_evt;
  wire ext_start = in_run && ext_r && (dly_cnt_r == DCW'(1));
  wire ms_tick = (pre_cnt_r == MCW'(MS_CYCLES - 1));
  wire int_start = in_run && !ext_r && ms_tick && (ms_cnt_r == dur_r - DUR_MIN + DUR_MIN - 16'h0001);
  wire rnd_end = in_run && !lin_r && (st_idx_r == RANDOM_STATES);
  wire trans_start = run_go || ((ext_start || int_start) && !rnd_end);
  wire trans_done = (tr_cnt_r == TCW'(1));

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_STOP: if (run_r) st_nxt = ST_RUN;
      ST_RUN: begin
        if (!run_r) st_nxt = ST_STOP;
        else if (rnd_end) st_nxt = ST_DONE;
      end
      ST_DONE: if (!run_r) st_nxt = ST_STOP;
      default: st_nxt = ST_STOP;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ST_STOP;
      dly_cnt_r <= '0;
      tr_cnt_r <= '0;
      pre_cnt_r <= '0;
      ms_cnt_r <= 16'h0000;
      st_idx_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      if (trig_ok) dly_cnt_r <= DCW'(TRIG_DELAY_CYCLES);
      else if (dly_cnt_r != '0) dly_cnt_r <= dly_cnt_r - DCW'(1);
      if (trans_start) tr_cnt_r <= TCW'(TRANS_CYCLES);
      else if (tr_cnt_r != '0) tr_cnt_r <= tr_cnt_r - TCW'(1);
      if (trans_start || ms_tick) pre_cnt_r <= '0;
      else pre_cnt_r <= pre_cnt_r + MCW'(1);
      if (trans_start) ms_cnt_r <= 16'h0000;
      else if (ms_tick) ms_cnt_r <= ms_cnt_r + 16'h0001;
      if (run_go) st_idx_r <= 16'h0001;
      else if (trans_start) st_idx_r <= st_idx_r + 16'h0001;
    end
  end

  // ---------------- per-path outputs ----------------
  logic [DLY_W-1:0] dly_out_r [NPATH];

  for (genvar p = 0; p < NPATH; p++) begin : g_path
    // one generator per path index, each driving only its own path's slice of angle_out
    aoa_path_angle #(
      .SEED(LFSR_SEED ^ 16'(p + 1))
    ) u_angle (
      .clk(hclk),
      .rst_n(hresetn),
      .load(run_go),
      .step(trans_start && !run_go),
      .linear(lin_r),
      .mean(mean_r[p]),
      .spread(spread_r[p]),
      .angle(angle_out[p*ANG_W +: ANG_W])
    );
    wire [DLY_W-1:0] ofs_w = {{(DLY_W-DOFS_W){1'b0}}, dofs_r[p]};
    wire [DLY_W-1:0] lim_w = DLY_RANGE_MAX - ofs_w;
    wire [DLY_W-1:0] base_w = path_delay_base[p*DLY_W +: DLY_W];
    wire [DLY_W-1:0] clip_w = (base_w > lim_w) ? lim_w : base_w;
    // delay frozen for the whole run
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        dly_out_r[p] <= 16'h0000;
      end else if (!running) begin
        dly_out_r[p] <= clip_w + ofs_w;
      end
    end
    assign path_delay_out[p*DLY_W +: DLY_W] = dly_out_r[p];
    assign phase_ofs_out[p*ANG_W +: ANG_W] = phase_r[p];
  end

  assign state_strobe = trans_start;
  assign transition_busy = (tr_cnt_r != '0);
  assign params_frozen = running;

  // ---------------- read mux ----------------
  wire [31:0] ctrl_rd = {28'h0000000, pri_r, ext_r, lin_r, run_r};
  wire [31:0] stat_rd = {st_idx_r, 12'h000, (st_r == ST_DONE), transition_busy, (dly_cnt_r != '0), running};
  wire [31:0] ang_rd = {4'h0, spread_r[a_idx], 4'h0, mean_r[a_idx]};
  wire [31:0] phs_rd = {20'h00000, phase_r[a_idx]};
  wire [31:0] dof_rd = {22'h000000, dofs_r[a_idx]};
  assign rd_mux = hit_ctrl ? ctrl_rd : hit_stat ? stat_rd : hit_dur ? {16'h0000, dur_r} :
                  hit_ang ? ang_rd : hit_phs ? phs_rd : hit_dof ? dof_rd : 32'h00000000;

  // ---------------- checks ----------------
  wire [DLY_W-1:0] ofs_first = {{(DLY_W-DOFS_W){1'b0}}, dofs_r[0]};
  logic [DCW:0] h_lat_r;
  logic [TCW:0] h_tr_r;
  logic [39:0] h_per_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      h_lat_r <= '0;
      h_tr_r <= '0;
      h_per_r <= 40'h0000000000;
    end else begin
      h_lat_r <= trig_ok ? '0 : h_lat_r + (DCW+1)'(1);
      h_tr_r <= trans_start ? '0 : h_tr_r + (TCW+1)'(1);
      h_per_r <= trans_start ? 40'h0000000000 : h_per_r + 40'h0000000001;
    end
  end

  a_phase_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_en && hit_phs && cfg_open |=> phase_ofs_out[a_idx*ANG_W +: ANG_W] <= PHASE_MAX)
    else $error("phase offset above full circle");
  a_delay_sum: assert property (@(posedge hclk) disable iff (!hresetn)
    !running |=> dly_out_r[0] <= DLY_RANGE_MAX && dly_out_r[0] >= $past(ofs_first))
    else $error("delay offset not added within range");
  a_mode_locked: assert property (@(posedge hclk) disable iff (!hresetn)
    running && $past(running) |-> $stable(lin_r) && $stable(ext_r))
    else $error("mode changed during a run");
  a_angle_only: assert property (@(posedge hclk) disable iff (!hresetn)
    running && !trans_start |=> $stable(angle_out) && $stable(path_delay_out))
    else $error("path values changed outside a transition");
  a_int_period: assert property (@(posedge hclk) disable iff (!hresetn)
    int_start |-> h_per_r == ({24'h000000, dur_r} * 40'(MS_CYCLES)) - 40'h0000000001)
    else $error("internal state duration wrong");
  a_trig_latency: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_start |-> h_lat_r == (DCW+1)'(TRIG_DELAY_CYCLES - 1))
    else $error("trigger to transition latency wrong");
  a_trans_len: assert property (@(posedge hclk) disable iff (!hresetn)
    trans_done |-> h_tr_r == (TCW+1)'(TRANS_CYCLES - 1) && TRANS_CYCLES <= TRANS_MAX_US * CLK_MHZ)
    else $error("transition length wrong");
  a_fwd_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    pri_r && ext_evt |=> sync_trig_out [*2])
    else $error("trigger not forwarded");
  a_retrig_busy: assert property (@(posedge hclk) disable iff (!hresetn)
    trig_ok && transition_busy |=> dly_cnt_r == DCW'(TRIG_DELAY_CYCLES))
    else $error("trigger lost during a transition");
  a_run_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !running |-> !ext_start && !int_start)
    else $error("state change before run");
  a_rand_count: assert property (@(posedge hclk) disable iff (!hresetn)
    running && !lin_r |-> st_idx_r <= RANDOM_STATES)
    else $error("random state count exceeded");
endmodule : aoa_state_sequencer
`default_nettype wire

// ### aoa_trig_src.sv
// partner model: external trigger source on the far side of the trigger pins
// assumes go is a one-cycle request from the bench, synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module aoa_trig_src #(
  parameter int HOLD_CYC = 20,
  parameter int GAP_CYC = 80
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] n_trig,
  output logic trig
);
  int cnt = 0;
  int left = 0;
  initial trig = 1'b0;
  always @(posedge clk) begin
    if (go) begin
      left <= n_trig;
      cnt <= 0;
    end else if (left > 0) begin
      trig <= (cnt < HOLD_CYC); // low-to-high edge, then held high
      cnt <= (cnt == GAP_CYC - 1) ? 0 : cnt + 1; // edges never closer than the rate limit
      if (cnt == GAP_CYC - 1) left <= left - 1;
    end else begin
      trig <= 1'b0;
    end
  end
endmodule : aoa_trig_src
`default_nettype wire

// ### aoa_state_sequencer_tb_top.sv
// self-checking bench for the angle-of-arrival state sequencer
// assumes scaled timing parameters: 1 ms is MSC cycles
`timescale 1ns/1ps
`default_nettype none
module aoa_state_sequencer_tb_top import aoa_pkg::*;;
  localparam int NP = NPATH_DEF;
  // trigger spacing of 4 ms must exceed the unscaled forward pulse, and a
  // retrigger must fall inside a transition
  localparam int MSC = 30;
  localparam int TDC = 108;
  localparam int TRC = 24;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, fwd, strb, busy, frozen, trig;
  logic [31:0] hrdata, rv;
  logic [NP*DLY_W-1:0] base = '0;
  logic [NP*DLY_W-1:0] dly;
  logic [NP*ANG_W-1:0] ang, phs;
  logic to_pri = 1'b1;
  logic go = 1'b0;
  logic [ANG_W-1:0] mean[NP], sp[NP], ph[NP];
  logic [DOFS_W-1:0] ofs[NP];
  logic [31:0] dv[5] = '{32'h3, 32'h4, 32'hEA60, 32'hEA61, 32'h5};
  logic [31:0] dx[5] = '{32'h4, 32'h4, 32'hEA60, 32'hEA60, 32'h5};
  int error_cnt = 0;
  int compares = 0;
  logic tr_d = 1'b0;
  logic fw_d = 1'b0;
  logic bz_d = 1'b0;
  int since_tr = 0;
  int since_st = 0;
  int blen = 0;
  int strb_n = 0;
  int fwd_n = 0;
  int lat_q[$], per_q[$], bus_q[$];
  logic [NP*ANG_W-1:0] ang_q[$];

  aoa_state_sequencer #(.NPATH(NP), .TRIG_DELAY_CYCLES(TDC), .TRANS_CYCLES(TRC), .MS_CYCLES(MSC)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ext_trig_in(trig & to_pri), .sync_trig_in(trig & ~to_pri), .sync_trig_out(fwd),
    .path_delay_base(base), .path_delay_out(dly), .angle_out(ang), .phase_ofs_out(phs),
    .state_strobe(strb), .transition_busy(busy), .params_frozen(frozen)
  );
  // trigger reaches the pin when the unit acts as primary, and the cable input when it acts as secondary
  aoa_trig_src #(.HOLD_CYC(20), .GAP_CYC(4 * MSC)) src_u (.clk(hclk), .go(go), .n_trig(4'h3), .trig(trig));

  initial begin
    forever #5 hclk = ~hclk;
  end

  always @(negedge hclk) begin
    since_tr = (trig && !tr_d) ? 0 : since_tr + 1;
    tr_d = trig;
    if (fwd && !fw_d) fwd_n++;
    fw_d = fwd;
    if (since_st == 2) ang_q.push_back(ang);
    if (strb === 1'b1) begin
      lat_q.push_back(since_tr);
      per_q.push_back(since_st);
      since_st = 1;
      strb_n++;
    end else since_st++;
    if (busy === 1'b1) blen++;
    else if (bz_d) begin
      bus_q.push_back(blen);
      blen = 0;
    end
    bz_d = busy;
  end

  task automatic final_report();
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
    if (n >= 100) begin
      error_cnt++;
      final_report();
    end
  endtask : bus

  function automatic logic [15:0] exp_dly(input logic [15:0] b, input logic [9:0] o);
    logic [15:0] lim;
    lim = DLY_RANGE_MAX - 16'(o);
    return ((b < lim) ? b : lim) + 16'(o);
  endfunction : exp_dly

  task automatic clr();
    lat_q.delete();
    per_q.delete();
    bus_q.delete();
    ang_q.delete();
    fwd_n = 0;
  endtask : clr

  task automatic chk_static();
    for (int p = 0; p < NP; p++) begin
      chk("phase", 32'(phs[p*ANG_W+:ANG_W]), 32'(ph[p]));
      chk("delay", 32'(dly[p*DLY_W+:DLY_W]), 32'(exp_dly(base[p*DLY_W+:DLY_W], ofs[p])));
    end
    foreach (bus_q[i]) chk("busy_len", bus_q[i], TRC);
  endtask : chk_static

  task automatic run_int(input logic [31:0] c);
    logic [11:0] v, pv, lo, hi;
    clr();
    bus(1'b1, ADDR_CTRL, c, rv);
    repeat (420) @(posedge hclk);
    bus(1'b0, ADDR_STATUS, 32'h0, rv);
    chk("running", {31'h0, rv[0]}, 32'h1);
    chk("frozen", {31'h0, frozen}, 32'h1);
    bus(1'b1, {GRP_PHASE, 3'h0, 2'b00}, 32'h5, rv);
    bus(1'b1, ADDR_DUR, 32'h9, rv);
    bus(1'b1, ADDR_CTRL, 32'h8, rv);
    repeat (40) @(posedge hclk);
    bus(1'b0, ADDR_DUR, 32'h0, rv);
    chk("dur_held", rv, 32'h5);
    chk_static();
    for (int i = 1; i < per_q.size(); i++) chk("period", per_q[i], 5 * MSC);
    for (int i = 0; i < ang_q.size(); i++) begin
      for (int p = 0; p < NP; p++) begin
        v = ang_q[i][p*ANG_W+:ANG_W];
        pv = (i > 0) ? ang_q[i-1][p*ANG_W+:ANG_W] : v;
        lo = mean[p] - sp[p];
        hi = mean[p] + sp[p];
        if (i == 0) chk("ang_first", 32'(v), 32'(mean[p]));
        else if (c[CTRL_LIN]) chk("ang_lin", 32'(v), 32'((pv == hi) ? lo : pv + 12'h1));
        else chk("ang_rnd", 32'(v >= lo && v <= hi), 32'h1);
      end
    end
  endtask : run_int

  initial begin
    repeat (100000) @(posedge hclk);
    error_cnt++;
    final_report();
  end

  initial begin
    void'($urandom(32'hD9E5013A));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, ADDR_CTRL, 32'h0, rv);
    chk("ctrl_rst", rv, 32'h8);
    bus(1'b0, 8'hFC, 32'h0, rv);
    chk("unmapped", rv, 32'h0);
    chk("phase_rst", {31'h0, |phs}, 32'h0);
    foreach (dv[i]) begin
      bus(1'b1, ADDR_DUR, dv[i], rv);
      bus(1'b0, ADDR_DUR, 32'h0, rv);
      chk("dur", rv, dx[i]);
    end
    for (int p = 0; p < NP; p++) begin
      mean[p] = 12'($urandom_range(3400, 100));
      sp[p] = (p == 0) ? 12'h0 : 12'($urandom_range(5, 1));
      ph[p] = (p == 0) ? PHASE_MAX : 12'($urandom_range(3600, 0));
      ofs[p] = (p == 0) ? DOFS_MAX : 10'($urandom_range(1000, 0));
      base[p*DLY_W+:DLY_W] <= (p == 0) ? DLY_RANGE_MAX : 16'($urandom_range(10000, 0));
      bus(1'b1, {GRP_ANGLE, 3'(p), 2'b00}, {4'h0, sp[p], 4'h0, mean[p]}, rv);
      bus(1'b1, {GRP_PHASE, 3'(p), 2'b00}, {20'h0, ph[p]}, rv);
      bus(1'b1, {GRP_DOFS, 3'(p), 2'b00}, {22'h0, ofs[p]}, rv);
    end
    repeat (5) @(posedge hclk);
    chk_static();
    chk("early_strobe", strb_n, 0);
    run_int(32'h9);
    run_int(32'hB);
    for (int k = 1; k >= 0; k--) begin
      to_pri <= k[0];
      bus(1'b1, ADDR_CTRL, k[0] ? 32'hD : 32'h5, rv);
      repeat (5) @(posedge hclk);
      clr();
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      repeat (400) @(posedge hclk);
      bus(1'b1, ADDR_CTRL, 32'h8, rv);
      chk("n_trig", lat_q.size(), 3);
      foreach (lat_q[i]) chk("trig_lat", lat_q[i], 3 + TDC);
      chk("fwd", fwd_n, k ? 3 : 0);
      chk_static();
    end
    final_report();
  end
endmodule : aoa_state_sequencer_tb_top
`default_nettype wire
